// >>> hw/rogc_top.sv
// option byte and pin control decoding behind an AHB-Lite slave
// Functional notes
// R1 - option bit 2 halves laser clock
// R2 - host pairs halving with spread spectrum
// R3 - option bit 3 picks 2.5m or 5m
// R4 - bit 4 set: pin event interrupts immediately
// R5 - bit 4 clear: interrupt waits for completion
// R6 - option bit 7 skips standby between runs
// R7 - pin modes in bits 3:0, 7:4
// R8 - mode 1: low aborts, high restarts
// R9 - mode 2: high aborts, low restarts
// R10 - mode 3 outputs laser pulse marker
// R11 - modes 4/5 static low/high, 4 default
// R12 - modes 6/7 detection indicator, inverse
// R13 - mode 8 open drain, released on detect
// R14 - mode 9 open drain, pulled on detect
// R15 - host never writes modes 10 to 15
// R16 - option bits 6:5 reserved, ignored
// R17 - pulse lead in 100us steps, falls at end
// R18 - completion sets flag, drives enabled pin
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
module rogc_top
    import rogc_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    // ahb-lite slave
    input  wire logic        HSEL_I,
    input  wire logic [7:0]  HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic [31:0]      HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // ranging engine
    input  wire logic        MEAS_DONE_I,
    input  wire logic        OBJ_DETECT_I,
    input  wire logic        LASER_REQ_I,
    input  wire logic        LASER_EMIT_I,
    output logic             MEAS_START_O,
    output logic             MEAS_ABORT_O,
    output logic             LASER_FIRE_O,
    output logic             LASER_CLK_HALF_O,
    output logic             LONG_RANGE_O,
    output logic             STANDBY_O,
    // pins
    input  wire logic [1:0]  PIN_I,
    output logic [1:0]       PIN_O,
    output logic [1:0]       PIN_OE_O,
    // interrupts
    output logic             IRQ_O,
    output logic             INT_N_O
);

    // ************************************************************
    // types and state
    // ************************************************************
    typedef enum logic [2:0] {
        MS_IDLE = 3'b001,
        MS_RUN  = 3'b010,
        MS_HOLD = 3'b100
    } rogc_meas_t;

    typedef enum logic [2:0] {
        LS_IDLE = 3'b001,
        LS_LEAD = 3'b010,
        LS_EMIT = 3'b100
    } rogc_lead_t;

    logic [7:0]  opt_q, opt_d;
    logic [7:0]  pctl_q, pctl_d;
    logic [7:0]  lead_q, lead_d;
    logic        pinen_q, pinen_d;
    logic [2:0]  mask_q, mask_d;
    logic [2:0]  stat_q, stat_d;
    logic        pend_q, pend_d;
    logic        wr_q, wr_d;
    logic [7:0]  addr_q, addr_d;
    logic [31:0] rdata_d;
    logic        start_req;
    rogc_meas_t  ms_q, ms_d;
    rogc_lead_t  ls_q, ls_d;
    logic [19:0] cnt_q, cnt_d;
    logic        pulse_q, pulse_d;
    logic        emit_q;
    logic        fire_d, mstart_d, mabort_d;
    logic [1:0]  inh;
    logic        inh_any, ev, lead_ev;
    logic        pulse_mode;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction : hit

    function automatic logic [19:0] lead_cycles(input logic [7:0] p);
        lead_cycles = 20'(p - 8'h01) * 20'(LEAD_STEP_CYC);
    endfunction : lead_cycles

    // ************************************************************
    // pins
    // ************************************************************
    for (genvar g = 0; g < 2; g++)
    begin : g_pin
        rogc_pin u_pin (
            .clk_i      (CLK_SYS_I),
            .rst_i      (RST_I),
            .mode_i     (pctl_q[4*g +: 4]), // R7
            .detect_i   (OBJ_DETECT_I),
            .pulse_on_i (pulse_q),
            .pin_i      (PIN_I[g]),
            .pin_o      (PIN_O[g]),
            .pin_oe_o   (PIN_OE_O[g]),
            .inhibit_o  (inh[g])
        );
    end

    assign inh_any    = |inh;
    assign pulse_mode = (pctl_q[3:0] == PM_PULSE) || (pctl_q[7:4] == PM_PULSE);

    // ************************************************************
    // bus and registers
    // ************************************************************
    always_comb
    begin
        addr_d    = addr_q;
        wr_d      = 1'b0;
        opt_d     = opt_q;
        pctl_d    = pctl_q;
        lead_d    = lead_q;
        pinen_d   = pinen_q;
        mask_d    = mask_q;
        start_req = 1'b0;
        rdata_d   = HRDATA_O;
        stat_d    = stat_q;
        if (HSEL_I && HREADY_I && HTRANS_I[1])
        begin
            addr_d = HADDR_I;
            wr_d   = HWRITE_I;
            rdata_d = 32'h0;
            if (!HWRITE_I)
            begin
                if (hit(HADDR_I, OFS_MEAS_OPT))
                    rdata_d[7:0] = opt_q;
                if (hit(HADDR_I, OFS_PIN_CTRL))
                    rdata_d[7:0] = pctl_q;
                if (hit(HADDR_I, OFS_PULSE_LD))
                    rdata_d[7:0] = lead_q;
                if (hit(HADDR_I, OFS_CTRL))
                    rdata_d[CTRL_PINEN_BIT] = pinen_q;
                if (hit(HADDR_I, OFS_IRQ_MASK))
                    rdata_d[2:0] = mask_q;
                if (hit(HADDR_I, OFS_STATUS))
                begin
                    rdata_d[2:0]         = stat_q;
                    rdata_d[ST_RUN_BIT]  = (ms_q == MS_RUN);
                    rdata_d[ST_HOLD_BIT] = (ms_q == MS_HOLD);
                    stat_d = 3'h0;
                end
            end
        end
        if (wr_q)
        begin
            if (hit(addr_q, OFS_MEAS_OPT))
                opt_d = HWDATA_I[7:0] & OPT_WR_MASK; // R16
            if (hit(addr_q, OFS_PIN_CTRL))
                pctl_d = HWDATA_I[7:0]; // R7
            if (hit(addr_q, OFS_PULSE_LD))
                lead_d = HWDATA_I[7:0];
            if (hit(addr_q, OFS_IRQ_MASK))
                mask_d = HWDATA_I[2:0];
            if (hit(addr_q, OFS_CTRL))
            begin
                pinen_d   = HWDATA_I[CTRL_PINEN_BIT];
                start_req = HWDATA_I[CTRL_START_BIT];
            end
        end
        // sticky status: a set wins over the read clear
        if (MEAS_DONE_I && ms_q == MS_RUN)
            stat_d[ST_DONE_BIT] = 1'b1; // R18
        if ((ev && opt_q[OPT_EARLY_BIT]) || (pend_q && MEAS_DONE_I && ms_q == MS_RUN))
            stat_d[ST_EVENT_BIT] = 1'b1; // R4 R5
        if (lead_ev)
            stat_d[ST_LEAD_BIT] = 1'b1;
    end

    // deferred pin event waits for completion
    always_comb
    begin
        pend_d = pend_q;
        if (ev && !opt_q[OPT_EARLY_BIT])
            pend_d = 1'b1; // R5
        if (MEAS_DONE_I && ms_q == MS_RUN)
            pend_d = 1'b0;
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            addr_q      <= 8'h00;
            wr_q        <= 1'b0;
            opt_q       <= RST_MEAS_OPT;
            pctl_q      <= RST_PIN_CTRL; // R11
            lead_q      <= RST_PULSE_LD;
            pinen_q     <= 1'b0;
            mask_q      <= RST_IRQ_MASK;
            stat_q      <= 3'h0;
            pend_q      <= 1'b0;
            HRDATA_O    <= 32'h0;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end
        else
        begin
            addr_q      <= addr_d;
            wr_q        <= wr_d;
            opt_q       <= opt_d;
            pctl_q      <= pctl_d;
            lead_q      <= lead_d;
            pinen_q     <= pinen_d;
            mask_q      <= mask_d;
            stat_q      <= stat_d;
            pend_q      <= pend_d;
            HRDATA_O    <= rdata_d;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end
    end

    // ************************************************************
    // measurement sequencing
    // ************************************************************
    always_comb
    begin
        ms_d     = ms_q;
        mstart_d = 1'b0;
        mabort_d = 1'b0;
        ev       = 1'b0;
        case (ms_q)
            MS_IDLE:
                if (start_req)
                begin
                    ms_d     = inh_any ? MS_HOLD : MS_RUN;
                    mstart_d = !inh_any;
                end
            MS_RUN:
                if (inh_any)
                begin
                    ms_d     = MS_HOLD; // R8 R9
                    mabort_d = 1'b1;
                    ev       = 1'b1;
                end
                else if (MEAS_DONE_I)
                    ms_d = MS_IDLE;
            MS_HOLD:
                if (!inh_any)
                begin
                    ms_d     = MS_RUN; // R8 R9
                    mstart_d = 1'b1;
                end
            default:
                ms_d = MS_IDLE;
        endcase
    end

    // ************************************************************
    // laser pulse lead timing
    // ************************************************************
    always_comb
    begin
        ls_d    = ls_q;
        cnt_d   = cnt_q;
        pulse_d = pulse_q;
        fire_d  = 1'b0;
        lead_ev = 1'b0;
        case (ls_q)
            LS_IDLE:
                if (LASER_REQ_I)
                begin
                    if (pulse_mode && lead_q != 8'h00)
                    begin
                        pulse_d = 1'b1; // R10 R17
                        cnt_d   = lead_cycles(lead_q);
                        ls_d    = LS_LEAD;
                        if (lead_q == 8'h01)
                        begin
                            fire_d = 1'b1;
                            ls_d   = LS_EMIT;
                        end
                    end
                    else
                        fire_d = 1'b1;
                end
            LS_LEAD:
                if (cnt_q <= 20'h1)
                begin
                    fire_d = 1'b1; // R17
                    ls_d   = LS_EMIT;
                end
                else
                    cnt_d = cnt_q - 20'h1;
            LS_EMIT:
                if (emit_q && !LASER_EMIT_I)
                begin
                    pulse_d = 1'b0; // R17
                    lead_ev = 1'b1;
                    ls_d    = LS_IDLE;
                end
            default:
                ls_d = LS_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ms_q             <= MS_IDLE;
            ls_q             <= LS_IDLE;
            cnt_q            <= 20'h0;
            pulse_q          <= 1'b0;
            emit_q           <= 1'b0;
            MEAS_START_O     <= 1'b0;
            MEAS_ABORT_O     <= 1'b0;
            LASER_FIRE_O     <= 1'b0;
            LASER_CLK_HALF_O <= 1'b0;
            LONG_RANGE_O     <= 1'b0;
            STANDBY_O        <= 1'b1;
            IRQ_O            <= 1'b0;
            INT_N_O          <= 1'b1;
        end
        else
        begin
            ms_q             <= ms_d;
            ls_q             <= ls_d;
            cnt_q            <= cnt_d;
            pulse_q          <= pulse_d;
            emit_q           <= LASER_EMIT_I;
            MEAS_START_O     <= mstart_d;
            MEAS_ABORT_O     <= mabort_d;
            LASER_FIRE_O     <= fire_d;
            LASER_CLK_HALF_O <= opt_q[OPT_HALF_BIT]; // R1
            LONG_RANGE_O     <= opt_q[OPT_RANGE_BIT]; // R3
            STANDBY_O        <= (ms_q == MS_IDLE) && !opt_q[OPT_AWAKE_BIT]; // R6
            IRQ_O            <= |(stat_q & mask_q);
            INT_N_O          <= !(pinen_q && (|(stat_q & mask_q))); // R18
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_clock_halve: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // R1
        (wr_q && hit(addr_q, OFS_MEAS_OPT)) |=> ##1
        (LASER_CLK_HALF_O == $past(HWDATA_I[OPT_HALF_BIT], 2)))
        else $error("laser clock halving does not follow option");
    a_range_sel: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // R3
        (wr_q && hit(addr_q, OFS_MEAS_OPT)) |=> ##1
        (LONG_RANGE_O == $past(HWDATA_I[OPT_RANGE_BIT], 2)))
        else $error("range select does not follow option");
    a_early_irq: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // R4
        (ev && opt_q[OPT_EARLY_BIT]) |=> stat_q[ST_EVENT_BIT])
        else $error("early pin event not flagged");
    a_withhold_irq: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // R5
        (!opt_q[OPT_EARLY_BIT] && !stat_q[ST_EVENT_BIT] && !MEAS_DONE_I)
        |=> !stat_q[ST_EVENT_BIT])
        else $error("pin event flagged before completion");
    a_stay_awake: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // R6
        opt_q[OPT_AWAKE_BIT] |=> !STANDBY_O)
        else $error("standby entered while kept awake");
    a_inhibit_abort: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // R8 R9
        (ms_q == MS_RUN && inh_any) |=> (MEAS_ABORT_O && ms_q == MS_HOLD))
        else $error("inhibit did not abort measurement");
    a_restart: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // R8 R9
        (ms_q == MS_HOLD && !inh_any) |=> MEAS_START_O)
        else $error("release of inhibit did not restart");
    a_zero_lead: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // R17
        (ls_q == LS_IDLE && LASER_REQ_I && pulse_mode && lead_q == 8'h01)
        |=> (LASER_FIRE_O && pulse_q))
        else $error("lead of zero did not fire with pin high");
    a_done_flag: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // R18
        (MEAS_DONE_I && ms_q == MS_RUN) |=> stat_q[ST_DONE_BIT])
        else $error("completion flag not set");

endmodule : rogc_top

// >>> common/rogc_pkg.sv
// constants shared by the ranging option and pin control block
package rogc_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_MEAS_OPT  = 8'h00;
    localparam logic [7:0] OFS_PIN_CTRL  = 8'h04;
    localparam logic [7:0] OFS_PULSE_LD  = 8'h08;
    localparam logic [7:0] OFS_CTRL      = 8'h0c;
    localparam logic [7:0] OFS_STATUS    = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_MEAS_OPT  = 8'h00;
    localparam logic [7:0] RST_PIN_CTRL  = 8'h44;
    localparam logic [7:0] RST_PULSE_LD  = 8'h00;
    localparam logic [2:0] RST_IRQ_MASK  = 3'h0;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int OPT_HALF_BIT   = 2;
    localparam int OPT_RANGE_BIT  = 3;
    localparam int OPT_EARLY_BIT  = 4;
    localparam int OPT_AWAKE_BIT  = 7;
    localparam logic [7:0] OPT_WR_MASK = 8'h9c;
    localparam int CTRL_PINEN_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int ST_DONE_BIT    = 0;
    localparam int ST_EVENT_BIT   = 1;
    localparam int ST_LEAD_BIT    = 2;
    localparam int ST_RUN_BIT     = 8;
    localparam int ST_HOLD_BIT    = 9;

    // ************************************************************
    // pin modes
    // ************************************************************
    typedef enum logic [3:0] {
        PM_OFF    = 4'h0,
        PM_INH_LO = 4'h1,
        PM_INH_HI = 4'h2,
        PM_PULSE  = 4'h3,
        PM_LOW    = 4'h4,
        PM_HIGH   = 4'h5,
        PM_DET_HI = 4'h6,
        PM_DET_LO = 4'h7,
        PM_OD_REL = 4'h8,
        PM_OD_PUL = 4'h9
    } rogc_mode_t;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ        = 40_000_000;
    localparam int LEAD_STEP_US  = 100;
    localparam int LEAD_STEP_CYC = (LEAD_STEP_US * (CLK_HZ / 1_000_000));

endpackage : rogc_pkg

// >>> hw/rogc_pin.sv
// one configurable pin: input inhibit or output indicator
module rogc_pin
    import rogc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // control
    input  wire logic [3:0] mode_i,
    input  wire logic       detect_i,
    input  wire logic       pulse_on_i,
    // pin
    input  wire logic       pin_i,
    output logic            pin_o,
    output logic            pin_oe_o,
    output logic            inhibit_o
);

    logic meta_q, sync_q;
    logic pin_d, oe_d, inh_d;

    always_comb
    begin
        pin_d = 1'b0;
        oe_d  = 1'b0;
        inh_d = 1'b0;
        case (mode_i)
            PM_INH_LO: inh_d = ~sync_q; // R8
            PM_INH_HI: inh_d = sync_q; // R9
            PM_PULSE:
            begin
                oe_d  = 1'b1;
                pin_d = pulse_on_i; // R10
            end
            PM_LOW:    oe_d = 1'b1; // R11
            PM_HIGH:
            begin
                oe_d  = 1'b1;
                pin_d = 1'b1; // R11
            end
            PM_DET_HI:
            begin
                oe_d  = 1'b1;
                pin_d = detect_i; // R12
            end
            PM_DET_LO:
            begin
                oe_d  = 1'b1;
                pin_d = ~detect_i; // R12
            end
            PM_OD_REL: oe_d = ~detect_i; // R13
            PM_OD_PUL: oe_d = detect_i; // R14
            default:   oe_d = 1'b0; // R7 R15
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_q    <= 1'b0;
            sync_q    <= 1'b0;
            pin_o     <= 1'b0;
            pin_oe_o  <= 1'b1;
            inhibit_o <= 1'b0;
        end
        else
        begin
            meta_q    <= pin_i;
            sync_q    <= meta_q;
            pin_o     <= pin_d;
            pin_oe_o  <= oe_d;
            inhibit_o <= inh_d;
        end
    end

    a_od_release: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        (mode_i == PM_OD_REL && detect_i) |=> !pin_oe_o)
        else $error("open drain pin not released on detect");
    a_static_low: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        (mode_i == PM_LOW) |=> (pin_oe_o && !pin_o))
        else $error("mode low not driving low");

endmodule : rogc_pin

// >>> bench/rogc_engine.sv
// ranging engine stand-in: finishes runs and emits laser light
module rogc_engine
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // from block
    input  wire logic start_i,
    input  wire logic abort_i,
    input  wire logic fire_i,
    input  wire logic [31:0] run_len_i,
    // to block
    output logic      done_o,
    output logic      emit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int run_cnt;
    int emit_cnt;
    // abort cancels the run, a restart reloads it
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            run_cnt  <= 0;
            emit_cnt <= 0;
            done_o   <= 1'b0;
            emit_o   <= 1'b0;
        end
        else
        begin
            done_o   <= (run_cnt == 1);
            run_cnt  <= abort_i ? 0 : start_i ? run_len_i : (run_cnt > 0) ? run_cnt - 1 : 0;
            emit_cnt <= fire_i ? 6 : (emit_cnt > 0) ? emit_cnt - 1 : 0;
            emit_o   <= fire_i || emit_cnt > 1;
        end
    end
endmodule : rogc_engine

// >>> bench/rogc_top_tb.sv
// self-checking bench for the option and pin control block
module rogc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rogc_pkg::*;
    // ************************************************************
    // stimulus and wiring
    // ************************************************************
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        req = 1'b0;
    logic        det = 1'b0;
    logic [1:0]  ext_en = 2'h0;
    logic [1:0]  ext_v = 2'h0;
    logic [7:0]  lfsr = 8'h2c;
    logic        rd_dp = 1'b0;
    logic [31:0] q_v[$];
    logic [31:0] q_m[$];
    logic [1:0]  e_a;
    logic [1:0]  e_b;
    int          fails = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          t_hit;
    int          t0;
    logic [31:0] hrdata;
    logic        hready;
    logic        done;
    logic        emit;
    logic        mstart;
    logic        mabort;
    logic        fire;
    logic        half;
    logic        longr;
    logic        stby;
    logic        irq;
    logic        int_n;
    logic [1:0]  pin_o;
    logic [1:0]  pin_oe;
    wire  [1:0]  pin_i = (pin_oe & pin_o) | (~pin_oe & ((ext_en & ext_v) | ~ext_en));

    always #12.5ns clk = ~clk;
    always @(posedge clk) cyc++;

    rogc_top u_dut (.CLK_SYS_I(clk), .RST_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(),
        .MEAS_DONE_I(done), .OBJ_DETECT_I(det), .LASER_REQ_I(req), .LASER_EMIT_I(emit),
        .MEAS_START_O(mstart), .MEAS_ABORT_O(mabort), .LASER_FIRE_O(fire),
        .LASER_CLK_HALF_O(half), .LONG_RANGE_O(longr), .STANDBY_O(stby),
        .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(pin_oe), .IRQ_O(irq), .INT_N_O(int_n));

    rogc_engine u_eng (.clk_i(clk), .rst_i(rst), .start_i(mstart), .abort_i(mabort),
        .fire_i(fire), .run_len_i(200), .done_o(done), .emit_o(emit));

    // ************************************************************
    // checking helpers
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        q_v.push_back(v);
        q_m.push_back(m);
        bus(a, 1'b0, 32'h0);
    endtask : rd

    // read data checked in the data phase, oldest note first
    always @(posedge clk) rd_dp <= htrans[1] & ~hwrite & hready;
    always @(posedge clk)
    begin
        if (rd_dp && q_v.size() > 0)
        begin
            chk(hrdata & q_m[0], q_v[0] & q_m[0], "read data");
            void'(q_v.pop_front());
            void'(q_m.pop_front());
        end
    end

    function automatic logic hit(input int s);
        case (s)
            0: return pin_o[0] === 1'b1 && pin_oe[0] === 1'b1;
            1: return emit === 1'b1;
            2: return mabort === 1'b1;
            3: return mstart === 1'b1;
            4: return pin_o[0] === 1'b0;
            5: return emit === 1'b0;
            6: return irq === 1'b1;
            default: return done === 1'b1;
        endcase
    endfunction : hit

    task automatic wsig(input int s);
        int n;
        n = 0;
        while (!hit(s) && n < 20000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 20000)
            chk(32'h0, 32'h1, "wait timeout");
        t_hit = cyc;
    endtask : wsig

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    // {drive enable, level} a mode should give
    function automatic logic [1:0] pin_exp(input logic [3:0] m, input logic d);
        case (m)
            4'h3: return 2'b10;
            4'h4: return 2'b10;
            4'h5: return 2'b11;
            4'h6: return {1'b1, d};
            4'h7: return {1'b1, ~d};
            4'h8: return d ? 2'b00 : 2'b10;
            4'h9: return d ? 2'b10 : 2'b00;
            default: return 2'b00;
        endcase
    endfunction : pin_exp

    initial
    begin
        #(25ns * 60000);
        fails++;
        final_report();
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({25'h0, pin_oe, pin_o, stby, irq, int_n}, 32'h65, "reset levels");
        rd(OFS_PIN_CTRL, 32'h44, '1);
        rd(OFS_MEAS_OPT, 32'h0, '1);
        rd(8'h1c, 32'h0, '1);
        for (int i = 0; i < 6; i++)
        begin
            lfsr = lfsr_next(lfsr);
            bus(OFS_MEAS_OPT, 1'b1, {24'h0, lfsr});
            rd(OFS_MEAS_OPT, {24'h0, lfsr & 8'h9c}, '1);
            @(negedge clk);
            chk({29'h0, half, longr, stby}, {29'h0, lfsr[2], lfsr[3], ~lfsr[7]}, "opt");
        end
        for (int m = 0; m < 10; m++)
            for (int d = 0; d < 2; d++)
            begin
                @(posedge clk) det <= d[0];
                bus(OFS_PIN_CTRL, 1'b1, {24'h0, m[3:0], 4'(9 - m)});
                repeat (2) @(negedge clk);
                e_a = pin_exp(4'(9 - m), d[0]);
                e_b = pin_exp(m[3:0], d[0]);
                chk({28'h0, pin_oe, pin_o & pin_oe}, {28'h0, e_b[1], e_a[1],
                    e_b[1] & e_b[0], e_a[1] & e_a[0]}, "pin drive");
            end
        for (int p = 1; p < 4; p++)
        begin
            bus(OFS_PIN_CTRL, 1'b1, 32'h43);
            bus(OFS_PULSE_LD, 1'b1, 32'(p));
            rd(OFS_PULSE_LD, 32'(p), '1);
            @(posedge clk);
            req <= 1'b1;
            @(posedge clk);
            req <= 1'b0;
            wsig(0);
            t0 = t_hit;
            wsig(1);
            chk(32'(t_hit - t0), 32'((p - 1) * LEAD_STEP_CYC), "pulse lead");
            @(negedge clk);
            wsig(5);
            t0 = t_hit;
            chk({31'h0, pin_o[0]}, 32'h1, "pin high to emit end");
            wsig(4);
            chk(32'(t_hit - t0 < 3), 32'h1, "pin fall");
        end
        rd(OFS_STATUS, 32'h4, 32'h7);
        bus(OFS_IRQ_MASK, 1'b1, 32'h2);
        bus(OFS_MEAS_OPT, 1'b1, 32'h10);
        ext_en <= 2'b01;
        ext_v  <= 2'b01;
        bus(OFS_PIN_CTRL, 1'b1, 32'h41);
        bus(OFS_CTRL, 1'b1, 32'h3);
        wsig(3);
        rd(OFS_CTRL, 32'h1, '1);
        @(posedge clk);
        ext_v <= 2'b00;
        wsig(2);
        wsig(6);
        rd(OFS_STATUS, 32'h2, 32'h7);
        @(posedge clk);
        ext_v <= 2'b01;
        wsig(3);
        wsig(7);
        repeat (3) @(negedge clk);
        chk({31'h0, irq}, 32'h0, "masked done");
        rd(OFS_STATUS, 32'h1, 32'h7);
        bus(OFS_MEAS_OPT, 1'b1, 32'h0);
        bus(OFS_IRQ_MASK, 1'b1, 32'h7);
        ext_en <= 2'b10;
        ext_v  <= 2'b00;
        bus(OFS_PIN_CTRL, 1'b1, 32'h24);
        bus(OFS_CTRL, 1'b1, 32'h3);
        wsig(3);
        @(posedge clk);
        ext_v <= 2'b10;
        wsig(2);
        repeat (20) @(negedge clk);
        chk({31'h0, irq}, 32'h0, "early irq held back");
        @(posedge clk);
        ext_v <= 2'b00;
        wsig(3);
        wsig(6);
        chk({30'h0, irq, int_n}, 32'h2, "done irq and pin");
        rd(OFS_STATUS, 32'h3, 32'h7);
        rd(OFS_STATUS, 32'h0, 32'h7);
        repeat (3) @(negedge clk);
        chk({30'h0, irq, int_n}, 32'h1, "irq cleared");
        final_report();
    end
endmodule : rogc_top_tb
